// ### design/twi_slave_pkg.sv
// Constants, register map and engine states for the two-wire slave.
// Assumes a byte-wide register port with a 4-bit address.
package twi_slave_pkg;
	localparam logic [3:0] OFS_SHARED = 4'h0;
	localparam logic [3:0] OFS_SLAVE = 4'h8;
	localparam logic [2:0] IDX_SLAVE_CONTROL_A = 3'h0;
	localparam logic [2:0] IDX_SLAVE_CONTROL_B = 3'h1;
	localparam logic [2:0] IDX_STATUS = 3'h2;
	localparam logic [2:0] IDX_ADDR = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [2:0] IDX_MASK = 3'h5;
	localparam logic [7:0] VEC_MASTER = 8'h00;
	localparam logic [7:0] VEC_SLAVE = 8'h02;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int CA_SMART_MODE_ENABLE = 0;
	localparam int CA_PROMISCUOUS_ENABLE = 1;
	localparam int CA_STOP_IRQ_ENABLE = 2;
	localparam int CA_EN = 3;
	localparam int CA_APIEN = 4;
	localparam int CA_DIEN = 5;
	localparam int CB_ACKNOWLEDGE_ACTION = 2;
	localparam int ST_DIF = 7;
	localparam int ST_ADDRESS_STOP_IRQ_FLAG = 6;
	localparam int ST_COLL = 3;
	localparam logic [1:0] CMD_DONE = 2'h2;
	localparam logic [1:0] CMD_RESP = 2'h3;
	localparam logic [6:0] GEN_CALL = 7'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX = 4'h7;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_HOLD = 3'h3,
		ST_ACK = 3'h2,
		ST_RX = 3'h6,
		ST_TX = 3'h7,
		ST_MACK = 3'h5
	} state_t;
endpackage

// ### design/line_sync.sv
// Two-stage synchroniser for the bus pins.
// Assumes inputs asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module line_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in, synced out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// Idle bus is high, so reset to ones
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '1;
			q <= '1;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### design/addr_match.sv
// Address comparator for the first byte after a start.
// Assumes a stable received byte when evaluated.
`timescale 1ns/100ps
`default_nettype none
module addr_match (
	// Received byte and settings
	input wire logic [7:0] rx_byte,
	input wire logic [7:0] own_addr,
	input wire logic [7:0] mask_reg,
	input wire logic promiscuous_enable,
	// Result
	output logic hit
);
	logic second_address_enable;
	logic [6:0] mask_bits;

	function automatic logic masked_eq(input logic [6:0] a, input logic [6:0] b, input logic [6:0] m);
		masked_eq = ((a ^ b) & ~m) == 7'h00;
	endfunction

	assign second_address_enable = mask_reg[0];
	// Mask applies only in single-address mode
	assign mask_bits = second_address_enable ? 7'h00 : mask_reg[7:1];

	// Bit 0 of the received byte is direction, never compared
	// A ten-bit prefix matches through the same upper bits
	always_comb
	begin
		hit = promiscuous_enable;
		if (masked_eq(rx_byte[7:1], own_addr[7:1], mask_bits))
			hit = 1'b1;
		if (second_address_enable && masked_eq(rx_byte[7:1], mask_reg[7:1], 7'h00))
			hit = 1'b1;
		if (own_addr[0] && rx_byte[7:1] == twi_slave_pkg::GEN_CALL)
			hit = 1'b1;
	end
endmodule
`default_nettype wire

// ### design/twi_slave.sv
// Two-wire slave: address match, data register, clock stretching.
// Assumes open-drain pins resolved outside; register port on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module twi_slave (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Two-wire pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Slave request
	output logic slave_irq
);
	////////////////////////////////////////////////////////////////////////
	logic [1:0] pin_s;
	logic scl_s, sda_s, scl_p_q, sda_p_q, scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] shared_q, slave_control_a_q, own_q, mask_q, data_q, sh_q;
	logic acknowledge_action_q, dif_q, address_stop_irq_flag_q, dif_d, address_stop_irq_flag_d, dir_q, ap_q, rxack_q, coll_q, nack_q, fin_q, from_addr_q, irq_q;
	logic [3:0] cnt_q;
	twi_slave_pkg::state_t state_q;
	logic en, hold, addr_hit, addr_done, rx_done, set_dif, set_address_stop_irq_flag, wr_status, wr_slave_control_b;
	logic data_wr, data_rd, cmd_valid, cmd_done, clr_all, release_go, ack_eff;
	function automatic logic hit_reg(input logic [3:0] a, input logic [2:0] idx);
		hit_reg = a == (twi_slave_pkg::OFS_SLAVE | {1'b0, idx});
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Pin sampling and bus conditions
	line_sync #(.W(2)) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.d({scl_in, sda_in}),
		.q(pin_s)
	);
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
	////////////////////////////////////////////////////////////////////////
	// Register decode
	assign en = slave_control_a_q[twi_slave_pkg::CA_EN];
	assign hold = dif_q || address_stop_irq_flag_q;
	assign wr_status = reg_wr && hit_reg(reg_addr, twi_slave_pkg::IDX_STATUS);
	assign wr_slave_control_b = reg_wr && hit_reg(reg_addr, twi_slave_pkg::IDX_SLAVE_CONTROL_B);
	// Data register locked while a byte is on the wire
	assign data_wr = reg_wr && hold && hit_reg(reg_addr, twi_slave_pkg::IDX_DATA);
	assign data_rd = reg_rd && hold && hit_reg(reg_addr, twi_slave_pkg::IDX_DATA);
	assign cmd_done = reg_wdata[1:0] == twi_slave_pkg::CMD_DONE;
	assign cmd_valid = wr_slave_control_b && hold && (cmd_done || reg_wdata[1:0] == twi_slave_pkg::CMD_RESP);
	assign clr_all = cmd_valid || data_wr || data_rd;
	// New action bit in the same write takes effect first
	assign ack_eff = wr_slave_control_b ? reg_wdata[twi_slave_pkg::CB_ACKNOWLEDGE_ACTION] : acknowledge_action_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shared_q <= twi_slave_pkg::RST_BYTE;
			slave_control_a_q <= twi_slave_pkg::RST_BYTE;
			acknowledge_action_q <= 1'b0;
			own_q <= twi_slave_pkg::RST_BYTE;
			mask_q <= twi_slave_pkg::RST_BYTE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == twi_slave_pkg::OFS_SHARED)
				shared_q <= {6'h00, reg_wdata[1:0]};
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_SLAVE_CONTROL_A))
				slave_control_a_q <= reg_wdata;
			if (wr_slave_control_b)
				acknowledge_action_q <= reg_wdata[twi_slave_pkg::CB_ACKNOWLEDGE_ACTION];
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_ADDR))
				own_q <= reg_wdata;
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_MASK))
				mask_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address comparison and engine events
	addr_match u_match (
		.rx_byte(sh_q),
		.own_addr(own_q),
		.mask_reg(mask_q),
		.promiscuous_enable(slave_control_a_q[twi_slave_pkg::CA_PROMISCUOUS_ENABLE]),
		.hit(addr_hit)
	);

	assign addr_done = state_q == twi_slave_pkg::ST_ADDR && scl_fall && cnt_q == twi_slave_pkg::BYTE_BITS;
	assign rx_done = state_q == twi_slave_pkg::ST_RX && scl_fall && cnt_q == twi_slave_pkg::BYTE_BITS;
	assign set_address_stop_irq_flag = en && !start_c && ((addr_done && addr_hit)
		|| (stop_c && slave_control_a_q[twi_slave_pkg::CA_STOP_IRQ_ENABLE]));
	// After address ack on a read, the data flag asks for the first byte
	assign set_dif = en && !start_c && !stop_c && scl_fall && (rx_done || state_q == twi_slave_pkg::ST_MACK
		|| (state_q == twi_slave_pkg::ST_ACK && !nack_q && !fin_q && from_addr_q && dir_q));
	////////////////////////////////////////////////////////////////////////
	// Interrupt flags; a set beats any clear in the same cycle
	always_comb
	begin
		dif_d = dif_q;
		address_stop_irq_flag_d = address_stop_irq_flag_q;
		if (clr_all || (wr_status && reg_wdata[twi_slave_pkg::ST_DIF]))
			dif_d = 1'b0;
		if (clr_all || (wr_status && reg_wdata[twi_slave_pkg::ST_ADDRESS_STOP_IRQ_FLAG]))
			address_stop_irq_flag_d = 1'b0;
		if (set_dif)
			dif_d = 1'b1;
		if (set_address_stop_irq_flag)
			address_stop_irq_flag_d = 1'b1;
	end
	assign release_go = hold && !dif_d && !address_stop_irq_flag_d;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dif_q <= 1'b0;
			address_stop_irq_flag_q <= 1'b0;
		end
		else
		begin
			dif_q <= dif_d;
			address_stop_irq_flag_q <= address_stop_irq_flag_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ap_q <= 1'b0;
		else if (set_address_stop_irq_flag)
			ap_q <= addr_done && addr_hit;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			coll_q <= 1'b0;
		else if (state_q == twi_slave_pkg::ST_TX && scl_rise && sh_q[7] && !sda_s)
			coll_q <= 1'b1;
		else if (start_c || (wr_status && reg_wdata[twi_slave_pkg::ST_COLL]))
			coll_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Data register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			data_q <= twi_slave_pkg::RST_BYTE;
		else if (rx_done)
			data_q <= sh_q;
		else if (data_wr)
			data_q <= reg_wdata;
	end
	////////////////////////////////////////////////////////////////////////
	// Bit engine
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= twi_slave_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= twi_slave_pkg::RST_BYTE;
			dir_q <= 1'b0;
			rxack_q <= 1'b0;
			nack_q <= 1'b0;
			fin_q <= 1'b0;
			from_addr_q <= 1'b0;
		end
		else if (!en || stop_c)
			state_q <= twi_slave_pkg::ST_IDLE;
		else if (start_c)
		begin
			state_q <= twi_slave_pkg::ST_ADDR;
			cnt_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				twi_slave_pkg::ST_IDLE:
					cnt_q <= 4'h0;
				twi_slave_pkg::ST_ADDR, twi_slave_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						sh_q <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end
					if (addr_done && addr_hit)
					begin
						dir_q <= sh_q[0];
						from_addr_q <= 1'b1;
						state_q <= twi_slave_pkg::ST_HOLD;
					end
					else if (addr_done)
						state_q <= twi_slave_pkg::ST_IDLE;
					if (rx_done)
					begin
						from_addr_q <= 1'b0;
						state_q <= twi_slave_pkg::ST_HOLD;
					end
				end
				twi_slave_pkg::ST_HOLD:
				begin
					cnt_q <= 4'h0;
					if (release_go)
					begin
						nack_q <= (cmd_valid || (data_rd && slave_control_a_q[twi_slave_pkg::CA_SMART_MODE_ENABLE])) ? ack_eff : 1'b0;
						fin_q <= cmd_valid && cmd_done;
						if (cmd_valid && cmd_done && dir_q)
							state_q <= twi_slave_pkg::ST_IDLE;
						else if (dir_q && !from_addr_q)
						begin
							sh_q <= data_wr ? reg_wdata : data_q;
							state_q <= rxack_q ? twi_slave_pkg::ST_IDLE : twi_slave_pkg::ST_TX;
						end
						else
							state_q <= twi_slave_pkg::ST_ACK;
					end
				end
				twi_slave_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						from_addr_q <= 1'b0;
						if (nack_q || fin_q)
							state_q <= twi_slave_pkg::ST_IDLE;
						else if (from_addr_q && dir_q)
							state_q <= twi_slave_pkg::ST_HOLD;
						else
							state_q <= twi_slave_pkg::ST_RX;
					end
				end
				twi_slave_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						sh_q <= {sh_q[6:0], 1'b1};
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == twi_slave_pkg::LAST_TX)
							state_q <= twi_slave_pkg::ST_MACK;
					end
				end
				twi_slave_pkg::ST_MACK:
				begin
					if (scl_rise)
						rxack_q <= sda_s;
					if (scl_fall)
						state_q <= twi_slave_pkg::ST_HOLD;
				end
				default:
					state_q <= twi_slave_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive: open drain, low only
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = hold;
	// A lost high bit stops data-bit driving in ST_TX until the next start or a status write to bit 3
	assign sda_oe = (state_q == twi_slave_pkg::ST_ACK && !nack_q)
		|| (state_q == twi_slave_pkg::ST_TX && !sh_q[7] && !coll_q);
	////////////////////////////////////////////////////////////////////////
	// Read port and request line
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= twi_slave_pkg::RST_BYTE;
		else if (reg_rd)
		begin
			reg_rdata <= twi_slave_pkg::RST_BYTE;
			if (reg_addr == twi_slave_pkg::OFS_SHARED)
				reg_rdata <= shared_q;
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_SLAVE_CONTROL_A))
				reg_rdata <= slave_control_a_q;
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_SLAVE_CONTROL_B))
				reg_rdata <= {5'h00, acknowledge_action_q, 2'h0};
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_STATUS))
				reg_rdata <= {dif_q, address_stop_irq_flag_q, hold, rxack_q, coll_q, 1'b0, dir_q, ap_q};
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_ADDR))
				reg_rdata <= own_q;
			if (data_rd)
				reg_rdata <= data_q;
			if (hit_reg(reg_addr, twi_slave_pkg::IDX_MASK))
				reg_rdata <= mask_q;
		end
	end
	// Request needs a nonzero level in control A bits 7:6 and an enabled flag set
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= slave_control_a_q[7:6] != 2'h0 && ((dif_q && slave_control_a_q[twi_slave_pkg::CA_DIEN])
				|| (address_stop_irq_flag_q && slave_control_a_q[twi_slave_pkg::CA_APIEN]));
	end

	assign slave_irq = irq_q;
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	dir_update_a: assert property (addr_done && addr_hit && en && !start_c && !stop_c |=> dir_q == $past(sh_q[0]))
		else $error("direction not taken from address byte");
	ap_source_a: assert property (set_address_stop_irq_flag |=> address_stop_irq_flag_q && ap_q == $past(addr_done))
		else $error("address-or-stop flag wrong");
	gen_call_a: assert property (addr_done && en && !start_c && !stop_c && own_q[0] && sh_q[7:1] == 7'h00
		|=> address_stop_irq_flag_q && state_q == twi_slave_pkg::ST_HOLD)
		else $error("general call not matched");
	promisc_a: assert property (addr_done && en && !start_c && !stop_c && slave_control_a_q[twi_slave_pkg::CA_PROMISCUOUS_ENABLE]
		|=> address_stop_irq_flag_q)
		else $error("promiscuous address not accepted");
	data_lock_a: assert property (reg_wr && !hold && hit_reg(reg_addr, twi_slave_pkg::IDX_DATA) && !rx_done
		|=> data_q == $past(data_q))
		else $error("data written while byte in flight");
	rx_store_a: assert property (rx_done && en && !start_c && !stop_c |=> data_q == $past(sh_q) && dif_q && scl_oe)
		else $error("received byte not stored with hold");
	access_clear_a: assert property ((data_wr || data_rd || cmd_valid) && !set_dif && !set_address_stop_irq_flag
		|=> !dif_q && !address_stop_irq_flag_q && !scl_oe)
		else $error("access did not release clock");
	cmd_zero_a: assert property (reg_rd && hit_reg(reg_addr, twi_slave_pkg::IDX_SLAVE_CONTROL_B) |=> reg_rdata[1:0] == 2'h0)
		else $error("command field read back nonzero");
	stop_flag_a: assert property (stop_c && en && slave_control_a_q[twi_slave_pkg::CA_STOP_IRQ_ENABLE] |=> address_stop_irq_flag_q && !ap_q)
		else $error("stop did not set flag");
	ack_drive_a: assert property (state_q == twi_slave_pkg::ST_HOLD && release_go && cmd_valid && en
		&& !start_c && !stop_c |=> nack_q == $past(reg_wdata[twi_slave_pkg::CB_ACKNOWLEDGE_ACTION]))
		else $error("acknowledge action not applied");
	addr_hold_c: cover property (addr_done && addr_hit ##[1:200] release_go);
	tx_byte_c: cover property (state_q == twi_slave_pkg::ST_MACK && scl_fall);
	rx_byte_c: cover property (rx_done);
	stop_c_c: cover property (stop_c && slave_control_a_q[twi_slave_pkg::CA_STOP_IRQ_ENABLE]);
endmodule
`default_nettype wire

// ### sim/twi_master_model.sv
// Behavioural two-wire bus master that drives the slave's pins.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module twi_master_model (
	// Released levels, 1 = let go
	output logic scl_o,
	output logic sda_o,
	// Resolved wire levels
	input wire logic scl_w,
	input wire logic sda_w
);
	// Idle bus, both lines released
	initial
	begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One 400 ns bit; a slave stretch simply delays the high phase
	task automatic bit_io(input logic b, output logic r);
		#50 sda_o = b;
		#150 scl_o = 1'h1;
		wait (scl_w === 1'h1);
		#100 r = sda_w;
		#100 scl_o = 1'h0;
	endtask
	task automatic start_cond();
		#200 sda_o = 1'h0;
		#200 scl_o = 1'h0;
	endtask
	task automatic stop_cond();
		#50 sda_o = 1'h0;
		#150 scl_o = 1'h1;
		wait (scl_w === 1'h1);
		#200 sda_o = 1'h1;
		#400;
	endtask
	// MSB first, then the slave's acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'h1, ack);
	endtask
	task automatic recv_byte(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'h1, r);
			b[i] = r;
		end
		bit_io(ack, r);
	endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the two-wire slave: register port and bus traffic.
// Assumes the master model on the far side and pull-ups on both wires.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, slave_irq, m_scl, m_sda, ack;
	wire scl_w;
	wire sda_w;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int seed = 32'h3E22;
	logic [7:0] d, rb;
	logic [7:0] q_data[$];
	logic [31:0] cases[11] = '{32'hA40000A4, 32'hA40000A5, 32'hA40000A6, 32'hA5000000, 32'hA4000000,
		32'hA40600A2, 32'hA4370036, 32'hA43700A4, 32'hA4370038, 32'hF20000F2, 32'hF20000F4};
	logic [3:0] rw_adr[7] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hB, 4'hD, 4'hE};
	logic [7:0] rw_msk[7] = '{8'h03, 8'h00, 8'hFF, 8'h04, 8'hFF, 8'hFF, 8'h00};
	always #25 ref_clk = ~ref_clk;
	// Open drain with pull-ups: any low driver wins
	assign scl_w = m_scl & ~(scl_oe & ~scl_out);
	assign sda_w = m_sda & ~(sda_oe & ~sda_out);
	twi_slave u_twi_slave (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .slave_irq(slave_irq));
	twi_master_model u_twi_master_model (.scl_o(m_scl), .sda_o(m_sda), .scl_w(scl_w), .sda_w(sda_w));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Gap cycle at entry so a strobe is never lowered and raised in one step
	task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wait_hold();
		int n;
		n = 0;
		while (scl_oe !== 1'h1 && n < 300)
		begin
			@(posedge ref_clk);
			n++;
		end
		#1 chk({7'h00, scl_oe}, 8'h01);
	endtask
	// Reference address match, worked on plain integers
	function automatic logic exp_hit(int own, int msk, int pm, int b);
		int a;
		a = b >> 1;
		if (pm != 0 || ((own & 1) != 0 && a == 0))
			return 1'h1;
		if ((msk & 1) != 0)
			return a == (own >> 1) || a == (msk >> 1);
		return ((a ^ (own >> 1)) & ~(msk >> 1) & 32'h7F) == 0;
	endfunction
	task automatic addr_case(input logic [7:0] own, input logic [7:0] msk, input logic pm, input logic [7:0] b);
		logic hit;
		hit = exp_hit(own, msk, pm, b);
		reg_write(4'hB, own);
		reg_write(4'hD, msk);
		reg_write(4'h8, {6'h16, pm, 1'h0});
		u_twi_master_model.start_cond();
		fork
			u_twi_master_model.send_byte(b, ack);
			if (hit)
			begin
				wait_hold();
				reg_check(4'hA, {6'h18, b[0], 1'h1});
				chk({7'h00, slave_irq}, 8'h01);
				reg_write(4'h9, {5'h00, b[1], 2'h2});
				#1 chk({7'h00, scl_oe}, 8'h00);
			end
		join
		chk({7'h00, ack}, {7'h00, !hit || b[0] || b[1]});
		u_twi_master_model.stop_cond();
	endtask
	task automatic stop_clear(input logic [7:0] st);
		u_twi_master_model.stop_cond();
		wait_hold();
		reg_check(4'hA, st);
		reg_write(4'hA, 8'hC0);
		#1 chk({7'h00, scl_oe}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int a = 0; a < 16; a++)
			reg_check(a[3:0], 8'h00);
		for (int k = 0; k < 7; k++)
		begin
			d = $random(seed);
			reg_write(rw_adr[k], d);
			reg_check(rw_adr[k], d & rw_msk[k]);
			reg_write(rw_adr[k], 8'h00);
		end
		// Data register is locked while the clock is not held
		reg_write(4'hC, 8'h5A);
		reg_check(4'hC, 8'h00);
		for (int k = 0; k < 11; k++)
			addr_case(cases[k][31:24], cases[k][23:16], cases[k][8], cases[k][7:0]);
		d = $random(seed);
		addr_case(8'hA4, 8'h00, 1'h1, d);
		// Master write: plain release, then smart mode with NACK
		reg_write(4'h8, 8'h7C);
		reg_write(4'hD, 8'h00);
		u_twi_master_model.start_cond();
		fork
			u_twi_master_model.send_byte(8'hA4, ack);
			begin
				wait_hold();
				reg_write(4'h9, 8'h03);
			end
		join
		chk({7'h00, ack}, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			d = $random(seed);
			q_data.push_back(d);
			reg_write(4'h8, {7'h3E, k[0]});
			reg_write(4'h9, 8'h04);
			fork
				u_twi_master_model.send_byte(d, ack);
				begin
					wait_hold();
					reg_check(4'hA, 8'hA1);
					reg_check(4'hC, q_data.pop_front());
					reg_check(4'hA, 8'h01);
				end
			join
			chk({7'h00, ack}, {7'h00, k[0]});
		end
		stop_clear(8'h60);
		// Master read, ended by the master's NACK
		reg_write(4'h9, 8'h00);
		u_twi_master_model.start_cond();
		fork
			u_twi_master_model.send_byte(8'hA5, ack);
			begin
				wait_hold();
				reg_check(4'hA, 8'h63);
				reg_write(4'h9, 8'h03);
			end
		join
		d = $random(seed);
		fork
			u_twi_master_model.recv_byte(1'h1, rb);
			begin
				wait_hold();
				reg_check(4'hA, 8'hA3);
				reg_write(4'hC, d);
			end
		join
		chk(rb, d);
		wait_hold();
		reg_check(4'hA, 8'hB3);
		reg_write(4'h9, 8'h02);
		stop_clear(8'h72);
		close_out();
	end
	// Whole run needs about two thousand cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			close_out();
		end
	end
endmodule
`default_nettype wire
